// *** src/asbl_host.sv ***
// host controller for a 512K x 16 asynchronous static memory
`timescale 1ns/1ns
`default_nettype none
`include "asbl_map.svh"
module asbl_host
  import asbl_pkg::*;
#(
  parameter int AW = `ASBL_ADDR_W,
  parameter int DW = `ASBL_DATA_W,
  parameter int RD_CYC = `ASBL_RD_CYC,
  parameter int WR_CYC = `ASBL_WR_CYC,
  parameter int TURN_CYC = `ASBL_TURN_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // user request
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [AW-1:0] REQ_ADDR,
  input wire logic [DW-1:0] REQ_WDATA,
  input wire logic [1:0] REQ_LANE_N,
  // user answer
  output logic RSP_VALID,
  output logic [DW-1:0] RSP_RDATA,
  // memory pins
  output logic [AW-1:0] MEM_ADDR,
  output logic CHIP_SELECT_LOW_ACTIVE,
  output logic CHIP_SELECT_HIGH_ACTIVE,
  output logic MEM_WRITE_N,
  output logic MEM_OUTPUT_N,
  output logic UPPER_BYTE_LANE_N,
  output logic LOWER_BYTE_LANE_N,
  input wire logic [DW-1:0] MEM_DQ_IN,
  output logic [DW-1:0] MEM_DQ_OUT,
  output logic [DW-1:0] MEM_DQ_OE
);
  function automatic logic [`ASBL_CNT_W-1:0] cnt_of(input int n);
    cnt_of = (n < 1) ? `ASBL_CNT_W'(0) : `ASBL_CNT_W'(n - 1);
  endfunction

  asbl_state_e state_reg, state_next;
  logic [`ASBL_CNT_W-1:0] cnt_reg;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] wdata_reg;
  logic [1:0] lane_reg;
  logic drive_reg;
  logic cnt_done;
  logic capture;
  logic [1:0] lane_next;

  ////////////////////////////////////////////////////////////////////
  // sequencing
  assign cnt_done = (cnt_reg == '0);
  assign REQ_READY = (state_reg == ASBL_IDLE);
  // both lanes high would deselect, so such requests are widened
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ASBL_IDLE: begin
        if (REQ_VALID) begin
          state_next = REQ_WRITE ? ASBL_WRITE : ASBL_READ;
        end
      end
      ASBL_READ: begin
        if (cnt_done) begin
          state_next = ASBL_TURN;
        end
      end
      ASBL_WRITE: begin
        if (cnt_done) begin
          state_next = ASBL_HOLD;
        end
      end
      ASBL_HOLD: state_next = ASBL_IDLE;
      ASBL_TURN: begin
        if (cnt_done) begin
          state_next = ASBL_IDLE;
        end
      end
      default: state_next = ASBL_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ASBL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_reg <= '0;
    end else if (state_reg == ASBL_IDLE && REQ_VALID) begin
      // read waits two more cycles for the input synchroniser
      cnt_reg <= REQ_WRITE ? cnt_of(WR_CYC) : cnt_of(RD_CYC + 2);
    end else if (state_next == ASBL_TURN && state_reg == ASBL_READ) begin
      cnt_reg <= cnt_of(TURN_CYC);
    end else if (!cnt_done) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_comb begin
    lane_next = lane_reg;
    if (state_reg == ASBL_IDLE && REQ_VALID) begin
      lane_next = (REQ_LANE_N == 2'h3) ? 2'h0 : REQ_LANE_N;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      addr_reg <= '0;
      wdata_reg <= '0;
      lane_reg <= 2'h3;
    end else if (state_reg == ASBL_IDLE && REQ_VALID) begin
      addr_reg <= REQ_ADDR;
      wdata_reg <= REQ_WDATA;
      lane_reg <= lane_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pins: selects always at a valid level, data held through HOLD
  assign MEM_ADDR = addr_reg;
  // strobes from flops: a decode glitch on a state change could write
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CHIP_SELECT_LOW_ACTIVE <= 1'b1;
      CHIP_SELECT_HIGH_ACTIVE <= 1'b0;
      MEM_WRITE_N <= 1'b1;
      MEM_OUTPUT_N <= 1'b1;
      UPPER_BYTE_LANE_N <= 1'b1;
      LOWER_BYTE_LANE_N <= 1'b1;
    end else begin
      CHIP_SELECT_LOW_ACTIVE <= (state_next == ASBL_IDLE);
      CHIP_SELECT_HIGH_ACTIVE <= (state_next != ASBL_IDLE);
      MEM_WRITE_N <= (state_next != ASBL_WRITE);
      MEM_OUTPUT_N <= (state_next != ASBL_READ);
      UPPER_BYTE_LANE_N <= (state_next == ASBL_IDLE) | lane_next[1];
      LOWER_BYTE_LANE_N <= (state_next == ASBL_IDLE) | lane_next[0];
    end
  end

  // drive only in write or its hold, never while reading or turning
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= (state_next == ASBL_WRITE)
        || (state_next == ASBL_HOLD);
    end
  end

  assign capture = (state_reg == ASBL_READ) && cnt_done;

  asbl_lane_drv #(.DW(DW)) u_lane (
    .clk(CLK),
    .rst(RST),
    .drive(drive_reg),
    .capture(capture),
    .lane_n(lane_reg),
    .wdata(wdata_reg),
    .dq_in(MEM_DQ_IN),
    .dq_out(MEM_DQ_OUT),
    .dq_oe(MEM_DQ_OE),
    .rdata(RSP_RDATA)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RSP_VALID <= 1'b0;
    end else begin
      RSP_VALID <= capture;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_no_contend;
    @(posedge CLK) disable iff (RST)
    !MEM_OUTPUT_N |-> (MEM_DQ_OE == '0);
  endproperty
  a_no_contend: assert property (p_no_contend)
    else $error("bus contention");

  property p_read_strobe;
    @(posedge CLK) disable iff (RST)
    !MEM_OUTPUT_N |-> MEM_WRITE_N;
  endproperty
  a_read_strobe: assert property (p_read_strobe)
    else $error("strobe in read");

  property p_sel_valid;
    @(posedge CLK) disable iff (RST)
    CHIP_SELECT_LOW_ACTIVE != CHIP_SELECT_HIGH_ACTIVE;
  endproperty
  a_sel_valid: assert property (p_sel_valid)
    else $error("selects split");

  property p_wr_width;
    @(posedge CLK) disable iff (RST)
    $fell(MEM_WRITE_N) |-> !MEM_WRITE_N [*3];
  endproperty
  a_wr_width: assert property (p_wr_width)
    else $error("strobe too short");

  property p_hold_data;
    @(posedge CLK) disable iff (RST)
    $rose(MEM_WRITE_N) |-> (MEM_DQ_OE != '0) && $stable(MEM_DQ_OUT);
  endproperty
  a_hold_data: assert property (p_hold_data)
    else $error("data hold lost");

  property p_wr_overlap;
    @(posedge CLK) disable iff (RST)
    !MEM_WRITE_N |-> !CHIP_SELECT_LOW_ACTIVE && CHIP_SELECT_HIGH_ACTIVE
      && !(UPPER_BYTE_LANE_N && LOWER_BYTE_LANE_N);
  endproperty
  a_wr_overlap: assert property (p_wr_overlap)
    else $error("write no overlap");

  property p_rsp_after;
    @(posedge CLK) disable iff (RST)
    RSP_VALID |-> $past(!MEM_OUTPUT_N);
  endproperty
  a_rsp_after: assert property (p_rsp_after)
    else $error("answer early");

  property p_turn;
    @(posedge CLK) disable iff (RST)
    $rose(MEM_OUTPUT_N) |-> (MEM_DQ_OE == '0) [*1] ##1 (MEM_DQ_OE == '0);
  endproperty
  a_turn: assert property (p_turn)
    else $error("no turnaround");
endmodule
`default_nettype wire

// *** src/asbl_map.svh ***
// timing counts and widths for the asynchronous static memory host
`ifndef ASBL_MAP_SVH
`define ASBL_MAP_SVH
`define ASBL_CLK_PERIOD_NS 20
`define ASBL_ADDR_W 19
`define ASBL_DATA_W 16
// read cycle time and address to data valid, ns
`define ASBL_T_READ_NS 45
`define ASBL_RD_CYC \
  ((`ASBL_T_READ_NS + `ASBL_CLK_PERIOD_NS - 1) / `ASBL_CLK_PERIOD_NS)
// write pulse width, least, ns
`define ASBL_T_PWE_NS 35
// data setup to write end, ns
`define ASBL_T_DSETUP_NS 25
// strobe low to outputs floated, ns
`define ASBL_T_HZWE_NS 18
// strobe must cover setup plus float while outputs stay enabled
`define ASBL_WR_SUM_NS \
  ((`ASBL_T_PWE_NS > (`ASBL_T_DSETUP_NS + `ASBL_T_HZWE_NS)) ? \
  `ASBL_T_PWE_NS : (`ASBL_T_DSETUP_NS + `ASBL_T_HZWE_NS))
`define ASBL_WR_CYC \
  ((`ASBL_WR_SUM_NS + `ASBL_CLK_PERIOD_NS - 1) / `ASBL_CLK_PERIOD_NS)
// output float after read, ns
`define ASBL_T_HZ_NS 18
`define ASBL_TURN_CYC \
  ((`ASBL_T_HZ_NS + `ASBL_CLK_PERIOD_NS - 1) / `ASBL_CLK_PERIOD_NS)
`define ASBL_CNT_W 4
`endif

// *** src/asbl_pkg.sv ***
// types for the asynchronous static memory host
package asbl_pkg;
  typedef enum logic [2:0] {
    ASBL_IDLE = 3'b000,
    ASBL_READ = 3'b001,
    ASBL_WRITE = 3'b010,
    ASBL_HOLD = 3'b011,
    ASBL_TURN = 3'b100
  } asbl_state_e;
endpackage

// *** src/asbl_lane_drv.sv ***
// data pin drive on all lanes at once, capture per byte lane
`timescale 1ns/1ns
`default_nettype none
module asbl_lane_drv
  import asbl_pkg::*;
#(
  parameter int DW = 16
) (
  // clock
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic drive,
  input wire logic capture,
  input wire logic [1:0] lane_n,
  input wire logic [DW-1:0] wdata,
  // pins
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic [DW-1:0] dq_oe,
  // captured data
  output logic [DW-1:0] rdata
);
  localparam int HW = DW / 2;
  logic [DW-1:0] sync1_reg, sync2_reg, sync3_reg;
  assign dq_out = wdata;
  assign dq_oe = drive ? {DW{1'b1}} : {DW{1'b0}};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= dq_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  // unenabled lanes float, so keep old byte rather than noise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (capture) begin
      if (!lane_n[0] && sync2_reg[HW-1:0] == sync3_reg[HW-1:0]) begin
        rdata[HW-1:0] <= sync3_reg[HW-1:0];
      end
      if (!lane_n[1] && sync2_reg[DW-1:HW] == sync3_reg[DW-1:HW]) begin
        rdata[DW-1:HW] <= sync3_reg[DW-1:HW];
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/asbl_mem_model.sv ***
// behavioural 16-bit asynchronous static memory with byte lanes
`timescale 1ns/1ns
`default_nettype none
module asbl_mem_model #(
  parameter int AW = 19
) (
  // address and controls
  input wire logic [AW-1:0] addr,
  input wire logic cs_low_n,
  input wire logic cs_high,
  input wire logic write_n,
  input wire logic output_n,
  input wire logic upper_n,
  input wire logic lower_n,
  // resolved data bus
  input wire logic [15:0] dq,
  // memory drive
  output logic [15:0] rd_data,
  output logic [15:0] rd_oe
);
  // sparse store, a full array would be wasteful
  logic [15:0] mem [logic [AW-1:0]];
  logic sel;
  logic wr;
  assign sel = !cs_low_n && cs_high && !(upper_n && lower_n);
  assign wr = sel && !write_n;
  // follows data during overlap, so the value at the ending edge stays
  always @(addr, wr, upper_n, lower_n, dq) begin
    if (wr && !lower_n)
      mem[addr][7:0] = dq[7:0];
    if (wr && !upper_n)
      mem[addr][15:8] = dq[15:8];
  end
  always @(addr, sel, write_n, output_n, upper_n, lower_n, dq) begin
    rd_data = mem.exists(addr) ? mem[addr] : 16'h0;
    if (sel && write_n && !output_n)
      rd_oe = {{8{!upper_n}}, {8{!lower_n}}};
    else
      rd_oe = 16'h0;
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the asynchronous static memory host
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [18:0] req_addr = 19'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [1:0] req_lane_n = 2'h3;
  logic [15:0] float_pat = 16'hA5A5;
  wire logic req_ready, rsp_valid, cs_lo_n, cs_hi, we_n, oe_n, ub_n, lb_n;
  wire logic [15:0] rsp_rdata, dq_out, dq_oe, mem_out, mem_oe, bus;
  wire logic [18:0] mem_addr;
  int n_mismatch = 0;
  int num_checks = 0;
  int wlow = 0;
  always #10 clk = ~clk;
  // undriven bits toggle so a stale value never looks valid
  always @(posedge clk) float_pat <= ~float_pat;
  assign bus = (dq_oe & dq_out) | (mem_oe & mem_out)
    | (~(dq_oe | mem_oe) & float_pat);
  asbl_host dut (.CLK(clk), .RST(rst), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .REQ_LANE_N(req_lane_n),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .MEM_ADDR(mem_addr),
    .CHIP_SELECT_LOW_ACTIVE(cs_lo_n), .CHIP_SELECT_HIGH_ACTIVE(cs_hi),
    .MEM_WRITE_N(we_n), .MEM_OUTPUT_N(oe_n), .UPPER_BYTE_LANE_N(ub_n),
    .LOWER_BYTE_LANE_N(lb_n), .MEM_DQ_IN(bus), .MEM_DQ_OUT(dq_out),
    .MEM_DQ_OE(dq_oe));
  asbl_mem_model mem (.addr(mem_addr), .cs_low_n(cs_lo_n),
    .cs_high(cs_hi), .write_n(we_n), .output_n(oe_n), .upper_n(ub_n),
    .lower_n(lb_n), .dq(bus), .rd_data(mem_out), .rd_oe(mem_oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic time_out;
    n_mismatch++;
    complete_run();
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic req(input logic wr, input logic [18:0] a,
      input logic [15:0] d, input logic [1:0] ln);
    int i;
    @(negedge clk);
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clk);
    if (i == 20) time_out();
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_lane_n = ln;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [18:0] a, input logic [1:0] ln,
      output logic [15:0] q);
    int i;
    req(1'b0, a, 16'h0, ln);
    for (i = 0; i < 12 && rsp_valid !== 1'b1; i++) @(negedge clk);
    if (i == 12) time_out();
    q = rsp_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // pin watch on every cycle out of reset
  always @(negedge clk) begin
    if (!rst) begin
      check({15'h0, cs_hi}, {15'h0, !cs_lo_n});
      check(dq_oe & mem_oe, 16'h0);
      if (oe_n === 1'b0) check({15'h0, we_n}, 16'h1);
      if (we_n === 1'b0) wlow++;
      else begin
        if (wlow != 0) check(16'(wlow >= 3), 16'h1);
        if (wlow != 0) check(dq_oe, 16'hFFFF);
        wlow = 0;
      end
    end
  end
  task automatic t_reset;
    check({10'h0, cs_lo_n, cs_hi, we_n, oe_n, ub_n, lb_n}, 16'h2F);
    check(dq_oe, 16'h0);
  endtask
  task automatic t_full;
    logic [15:0] q;
    req(1'b1, 19'h7FFFF, 16'h1234, 2'h0);
    req(1'b1, 19'h00000, 16'hBEEF, 2'h3);
    rd(19'h7FFFF, 2'h0, q);
    check(q, 16'h1234);
    rd(19'h00000, 2'h0, q);
    check(q, 16'hBEEF);
  endtask
  task automatic t_lower;
    logic [15:0] q;
    req(1'b1, 19'h7FFFF, 16'h55CD, 2'h2);
    rd(19'h7FFFF, 2'h2, q);
    check(q, 16'hBECD);
    rd(19'h7FFFF, 2'h0, q);
    check(q, 16'h12CD);
  endtask
  task automatic t_upper;
    logic [15:0] q;
    req(1'b1, 19'h7FFFF, 16'hAB66, 2'h1);
    rd(19'h00000, 2'h0, q);
    rd(19'h7FFFF, 2'h1, q);
    check(q, 16'hABEF);
    rd(19'h7FFFF, 2'h0, q);
    check(q, 16'hABCD);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_full();
    t_lower();
    t_upper();
    complete_run();
  end
endmodule
`default_nettype wire
